// [rtl/mcu_ctrl_pkg.sv]
// Offsets, reset values, timing counts and carrier types of the control register bank.
package mcu_ctrl_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] OFS_PORT2_DIR = 8'hf6;
  localparam logic [7:0] OFS_PORT3_CFG = 8'hf7;
  localparam logic [7:0] OFS_PORT01    = 8'hf8;
  localparam logic [7:0] OFS_PRIO      = 8'hf9;
  localparam logic [7:0] OFS_PEND      = 8'hfa;
  localparam logic [7:0] OFS_MASK      = 8'hfb;
  localparam logic [7:0] OFS_FLAGS     = 8'hfc;
  localparam logic [7:0] OFS_WGP       = 8'hfd;
  localparam logic [7:0] OFS_SPH       = 8'hfe;
  localparam logic [7:0] OFS_SPL       = 8'hff;

  // Reset values; ports come up as inputs so nothing is driven before software decides.
  localparam logic [7:0] RST_PORT2_DIR = 8'hff;
  localparam logic [7:0] RST_PORT01    = 8'h4d;
  localparam logic [7:0] RST_BYTE      = 8'h00;

  // Field values of the two-bit port mode fields.
  localparam logic [1:0] MODE_OUT   = 2'h0;
  localparam logic [1:0] MODE_IN    = 2'h1;
  localparam logic [1:0] MODE_BUS   = 2'h2;
  localparam logic [1:0] MODE_FLOAT = 2'h3;

  // Interrupt layout: six requests, global enable in the top mask bit.
  localparam int NUM_REQ    = 6;
  localparam int MASK_GLOBAL = 7;

  // Timing: one input clock period is one clk period here.
  localparam int CLK_PERIOD_NS   = 8;
  localparam int INPUT_CLOCK_PERIOD_NS = 8;
  localparam int EXT_EXTRA_NS    = 2 * INPUT_CLOCK_PERIOD_NS;
  localparam int EXT_EXTRA_CYC   = (EXT_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_NORM_CYC   = 2;
  localparam int DATA_EXT_CYC    = DATA_NORM_CYC + EXT_EXTRA_CYC;

  // Layout of port01_config, most significant field first.
  typedef struct packed {
    logic [1:0] p0HiMode;   // Upper four port 0 lines.
    logic       extTiming;  // Extended external memory timing.
    logic [1:0] p1Mode;     // Port 1 use.
    logic       stackInt;   // Stack in the internal register file.
    logic [1:0] p0LoMode;   // Lower four port 0 lines.
  } port01_s;

  // Plain register port from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrStb;
    logic       rdStb;
  } regbus_s;

  // External access request from the core.
  typedef struct packed {
    logic        req;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } extreq_s;

  // External memory bus pins.
  typedef struct packed {
    logic       addressStrobeN;
    logic       dataStrobeN;
    logic       readWriteN;
    logic       lowBusOutEn;
    logic [7:0] muxedLowBus;
    logic [7:0] addrHigh;
  } extbus_s;

  // Sequencer states of an external access.
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_DATA, SEQ_END} seq_e;

endpackage

// [rtl/mcu_port_irq_control_regs.sv]
// Upper control register bank: port modes, interrupt requests, stack pointer, external bus timing.
//
// Notes on behaviour
// - Port 2 direction one makes line input.
// - Port 2 direction zero makes line output.
// - Upper port 0 nibble: output, input, address.
// - Lower port 0 nibble: output, input, address.
// - Port 1: byte out, byte in, bus.
// - Port 1 mode 11 floats all bus lines.
// - Stack bit picks external or internal stack.
// - Extended timing adds two clocks per access.
// - Mode and priority registers are write only.
// - Request 0 stored; request 1 from edge.
// - Request 3 shared with serial receiver.
// - Pending requests readable and writable.
// - Stack pointer high byte readable, writable.
// - Stack pointer low byte readable, writable.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps

module mcu_port_irq_control_regs (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Register port.
  input  wire mcu_ctrl_pkg::regbus_s      regBus,
  output logic [7:0]                      rdData,
  // External access request from the core.
  input  wire mcu_ctrl_pkg::extreq_s      extReq,
  output logic                            extDone,
  // External bus pins.
  output mcu_ctrl_pkg::extbus_s           extPins,
  output logic                            strobeOutEn,
  // Port line use.
  output logic [7:0]                      port2OutEn,
  output logic                            port0HiOutEn,
  output logic                            port0HiAddrSel,
  output logic                            port0LoOutEn,
  output logic                            port0LoAddrSel,
  output logic                            port1OutEn,
  // Stack, pointers and flags.
  output logic                            stackInternal,
  output logic [15:0]                     stackPointer,
  output logic [7:0]                      workingGroupPointer,
  output logic [7:0]                      conditionFlags,
  output logic [7:0]                      port3Config,
  output logic [7:0]                      interruptPriority,
  // Interrupt sources and output.
  input  wire logic [3:0]                 port3In,
  input  wire logic                       serialRxReady,
  input  wire logic                       serialTxDone,
  input  wire logic                       timer0Done,
  input  wire logic                       timer1Done,
  output logic                            irqOut
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  // All state of the bank in one record.
  typedef struct packed {
    logic [7:0]                          port2Dir;   // One bit per port 2 line.
    logic [7:0]                          port3Cfg;   // Port 3 configuration.
    mcu_ctrl_pkg::port01_s               port01;     // Latest software setting.
    mcu_ctrl_pkg::port01_s               activeCfg;  // Setting the bus really uses.
    logic [7:0]                          prio;       // Interrupt priority.
    logic [mcu_ctrl_pkg::NUM_REQ-1:0]    pend;       // Pending requests.
    logic [7:0]                          mask;       // Request mask and global enable.
    logic [7:0]                          flags;      // Condition flags.
    logic [7:0]                          wgp;        // Working group pointer.
    logic [7:0]                          stack_pointer_high;        // Stack pointer high byte.
    logic [7:0]                          stack_pointer_low;        // Stack pointer low byte.
    logic [7:0]                          rdData;     // Read answer, one cycle only.
    mcu_ctrl_pkg::seq_e                  seq;        // External access phase.
    logic [2:0]                          cnt;        // Data phase cycles left.
    logic                                accWrite;   // Access direction.
    logic [7:0]                          accData;    // Write data of the access.
    logic                                done;       // Access finished pulse.
    mcu_ctrl_pkg::extbus_s               pins;       // Registered bus pins.
    logic [3:0]                          p3Sync1;    // First synchroniser stage.
    logic [3:0]                          p3Sync2;    // Second synchroniser stage.
    logic [3:0]                          p3Prev;     // Delayed copy for edge detection.
  } bank_s;

  bank_s s_r;   // Registered state.
  bank_s s_nxt; // Next state.

  logic [3:0]                       p3Fall;  // Falling edges on port 3 lines.
  logic [mcu_ctrl_pkg::NUM_REQ-1:0] events;  // Request sources this cycle.
  logic                             busFloat; // Port 1 mode floats the whole bus.

  ////////////////////////////////////////////////////////////////////////////////
  // Request sources.

  // Requests fire on falling edges of synchronised port 3 lines.
  // The delayed copy resets low, so a line idling high cannot fake an edge.
  assign p3Fall = s_r.p3Prev & ~s_r.p3Sync2;

  // Map sources onto request bits; several sources share a bit.
  // Shared sources are merged, so software cannot tell which one fired.
  always_comb begin
    events    = '0;
    events[0] = p3Fall[2];
    events[1] = p3Fall[3];
    events[2] = p3Fall[1];
    events[3] = p3Fall[0] | serialRxReady;
    events[4] = timer0Done | serialTxDone;
    events[5] = timer1Done;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Register writes, reads, request capture and the access sequencer.
  always_comb begin
    s_nxt         = s_r;
    // One-cycle outputs fall back to rest unless set below.
    s_nxt.rdData  = mcu_ctrl_pkg::RST_BYTE;
    s_nxt.done    = 1'b0;
    // Two flip-flops tame the asynchronous port 3 pins before any use.
    s_nxt.p3Sync1 = port3In;
    s_nxt.p3Sync2 = s_r.p3Sync1;
    s_nxt.p3Prev  = s_r.p3Sync2;

    // Writes store the byte; unmapped offsets are ignored.
    // Write-only registers still store here; only their read path is closed.
    if (regBus.wrStb) begin
      case (regBus.addr)
        mcu_ctrl_pkg::OFS_PORT2_DIR: s_nxt.port2Dir = regBus.wrData;
        mcu_ctrl_pkg::OFS_PORT3_CFG: s_nxt.port3Cfg = regBus.wrData;
        mcu_ctrl_pkg::OFS_PORT01:    s_nxt.port01 = mcu_ctrl_pkg::port01_s'(regBus.wrData);
        mcu_ctrl_pkg::OFS_PRIO:      s_nxt.prio = regBus.wrData;
        mcu_ctrl_pkg::OFS_PEND:      s_nxt.pend = regBus.wrData[mcu_ctrl_pkg::NUM_REQ-1:0];
        mcu_ctrl_pkg::OFS_MASK:      s_nxt.mask = regBus.wrData;
        mcu_ctrl_pkg::OFS_FLAGS:     s_nxt.flags = regBus.wrData;
        mcu_ctrl_pkg::OFS_WGP:       s_nxt.wgp = regBus.wrData;
        mcu_ctrl_pkg::OFS_SPH:       s_nxt.stack_pointer_high = regBus.wrData;
        mcu_ctrl_pkg::OFS_SPL:       s_nxt.stack_pointer_low = regBus.wrData;
        default: begin
        end
      endcase
    end

    // A source event beats a software clear in the same cycle, so none is lost.
    s_nxt.pend = s_nxt.pend | events;

    // Reads answer next cycle; write-only and unmapped offsets read zero.
    // A read changes no state, so pending requests can be inspected safely.
    if (regBus.rdStb) begin
      case (regBus.addr)
        mcu_ctrl_pkg::OFS_PEND:  s_nxt.rdData = {2'h0, s_r.pend};
        mcu_ctrl_pkg::OFS_MASK:  s_nxt.rdData = s_r.mask;
        mcu_ctrl_pkg::OFS_FLAGS: s_nxt.rdData = s_r.flags;
        mcu_ctrl_pkg::OFS_WGP:   s_nxt.rdData = s_r.wgp;
        mcu_ctrl_pkg::OFS_SPH:   s_nxt.rdData = s_r.stack_pointer_high;
        mcu_ctrl_pkg::OFS_SPL:   s_nxt.rdData = s_r.stack_pointer_low;
        default:                 s_nxt.rdData = mcu_ctrl_pkg::RST_BYTE;
      endcase
    end

    // External access sequencer: address phase, data phase, recovery.
    case (s_r.seq)
      mcu_ctrl_pkg::SEQ_IDLE: begin
        // Mode changes are picked up only between accesses.
        s_nxt.activeCfg = s_r.port01;
        // A request is taken only here; a busy sequencer ignores it.
        if (extReq.req) begin
          s_nxt.seq                 = mcu_ctrl_pkg::SEQ_ADDR;
          s_nxt.accWrite            = extReq.write;
          s_nxt.accData             = extReq.data;
          s_nxt.pins.addressStrobeN = 1'b0;
          s_nxt.pins.readWriteN     = ~extReq.write;
          s_nxt.pins.muxedLowBus    = extReq.addr[7:0];
          s_nxt.pins.addrHigh       = extReq.addr[15:8];
          s_nxt.pins.lowBusOutEn    = (s_r.port01.p1Mode == mcu_ctrl_pkg::MODE_BUS);
        end
      end
      mcu_ctrl_pkg::SEQ_ADDR: begin
        // Data phase length depends on the timing bit of this access.
        // Write data replaces the address on the low bus in the data phase.
        s_nxt.seq                 = mcu_ctrl_pkg::SEQ_DATA;
        s_nxt.pins.addressStrobeN = 1'b1;
        s_nxt.pins.dataStrobeN    = 1'b0;
        s_nxt.cnt = s_r.activeCfg.extTiming ? 3'(mcu_ctrl_pkg::DATA_EXT_CYC - 1)
                                            : 3'(mcu_ctrl_pkg::DATA_NORM_CYC - 1);
        s_nxt.pins.muxedLowBus = s_r.accWrite ? s_r.accData : s_r.pins.muxedLowBus;
        s_nxt.pins.lowBusOutEn = s_r.accWrite && (s_r.activeCfg.p1Mode == mcu_ctrl_pkg::MODE_BUS);
      end
      mcu_ctrl_pkg::SEQ_DATA: begin
        // The counter holds the data strobe low for the chosen length.
        if (s_r.cnt == 3'h0) begin
          s_nxt.seq              = mcu_ctrl_pkg::SEQ_END;
          s_nxt.pins.dataStrobeN = 1'b1;
          s_nxt.pins.lowBusOutEn = 1'b0;
          s_nxt.done             = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      mcu_ctrl_pkg::SEQ_END: begin
        // One recovery cycle keeps back-to-back accesses apart.
        s_nxt.seq             = mcu_ctrl_pkg::SEQ_IDLE;
        s_nxt.pins.readWriteN = 1'b1;
      end
      default: begin
        s_nxt.seq = mcu_ctrl_pkg::SEQ_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Every field takes a constant under reset.
  // Strobes and the read/write line rest high so no access shows at start-up.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r                     <= '0;
      s_r.port2Dir            <= mcu_ctrl_pkg::RST_PORT2_DIR;
      s_r.port01              <= mcu_ctrl_pkg::port01_s'(mcu_ctrl_pkg::RST_PORT01);
      s_r.activeCfg           <= mcu_ctrl_pkg::port01_s'(mcu_ctrl_pkg::RST_PORT01);
      s_r.seq                 <= mcu_ctrl_pkg::SEQ_IDLE;
      s_r.pins.addressStrobeN <= 1'b1;
      s_r.pins.dataStrobeN    <= 1'b1;
      s_r.pins.readWriteN     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Port 0, port 1 and strobe enables decode the active copy, never the raw write, so an access
  // in flight keeps its pin use to the end.
  assign rdData              = s_r.rdData;
  assign extDone             = s_r.done;
  assign extPins             = s_r.pins;
  assign port2OutEn          = ~s_r.port2Dir;
  assign stackInternal       = s_r.activeCfg.stackInt;
  assign stackPointer        = {s_r.stack_pointer_high, s_r.stack_pointer_low};
  assign workingGroupPointer = s_r.wgp;
  assign conditionFlags      = s_r.flags;
  assign port3Config         = s_r.port3Cfg;
  assign interruptPriority   = s_r.prio;

  // Strobes are driven only in bus mode; mode 11 floats them with the bus.
  assign strobeOutEn = (s_r.activeCfg.p1Mode == mcu_ctrl_pkg::MODE_BUS);
  assign port1OutEn  = (s_r.activeCfg.p1Mode == mcu_ctrl_pkg::MODE_OUT);

  // True while port 1 mode asks the whole bus to float; a plain net keeps
  // the enables below sensitive to every change of the active mode.
  assign busFloat = (s_r.activeCfg.p1Mode == mcu_ctrl_pkg::MODE_FLOAT);

  // Port 0 nibbles: address use floats too when port 1 is in mode 11.
  assign port0HiAddrSel = s_r.activeCfg.p0HiMode[1];
  assign port0HiOutEn   = (s_r.activeCfg.p0HiMode == mcu_ctrl_pkg::MODE_OUT) |
                          (s_r.activeCfg.p0HiMode[1] & ~busFloat);
  assign port0LoAddrSel = s_r.activeCfg.p0LoMode[1];
  assign port0LoOutEn   = (s_r.activeCfg.p0LoMode == mcu_ctrl_pkg::MODE_OUT) |
                          (s_r.activeCfg.p0LoMode[1] & ~busFloat);

  // Level interrupt: any unmasked pending request while globally enabled.
  // Without the global enable nothing reaches the core, whatever the mask.
  assign irqOut = s_r.mask[mcu_ctrl_pkg::MASK_GLOBAL] &
                  (|(s_r.pend & s_r.mask[mcu_ctrl_pkg::NUM_REQ-1:0]));

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Data strobe low for exactly the normal or extended number of cycles.
  sequence dsLowNormal;
    extPins.dataStrobeN == 1'b0 [*2] ##1 extPins.dataStrobeN;
  endsequence
  sequence dsLowExtended;
    extPins.dataStrobeN == 1'b0 [*4] ##1 extPins.dataStrobeN;
  endsequence

  // Normal timing holds the data strobe low for two cycles.
  chk_ds_normal_len : assert property (
    $fell(extPins.dataStrobeN) && !s_r.activeCfg.extTiming |-> dsLowNormal)
    else $error("Normal data strobe length wrong");

  // Extended timing adds two cycles to the strobe.
  chk_ds_extended_len : assert property (
    $fell(extPins.dataStrobeN) && s_r.activeCfg.extTiming |-> dsLowExtended)
    else $error("Extended data strobe length wrong");

  // A direction write shows on the enables one cycle later.
  chk_port2_dir_write : assert property (
    regBus.wrStb && regBus.addr == mcu_ctrl_pkg::OFS_PORT2_DIR |=> port2OutEn == ~$past(regBus.wrData))
    else $error("Port 2 direction not applied");

  // Write-only registers answer zero to software.
  chk_wo_reads_zero : assert property (
    regBus.rdStb && regBus.addr >= mcu_ctrl_pkg::OFS_PORT2_DIR && regBus.addr <= mcu_ctrl_pkg::OFS_PRIO
    |=> rdData == 8'h00)
    else $error("Write-only register read back");

  // The high stack byte reads back what was just written.
  chk_sph_readback : assert property (
    regBus.wrStb && regBus.addr == mcu_ctrl_pkg::OFS_SPH ##1 regBus.rdStb && regBus.addr == mcu_ctrl_pkg::OFS_SPH
    |=> rdData == $past(regBus.wrData, 2))
    else $error("Stack pointer high readback wrong");

  // The low stack byte behaves the same way.
  chk_spl_readback : assert property (
    regBus.wrStb && regBus.addr == mcu_ctrl_pkg::OFS_SPL ##1 regBus.rdStb && regBus.addr == mcu_ctrl_pkg::OFS_SPL
    |=> rdData == $past(regBus.wrData, 2))
    else $error("Stack pointer low readback wrong");

  // A falling edge on port 3 line 3 raises request one.
  chk_req_one_edge : assert property (
    p3Fall[3] |=> s_r.pend[1])
    else $error("Request one missed an edge");

  // The serial receiver raises request three.
  chk_rx_sets_three : assert property (
    serialRxReady |=> s_r.pend[3])
    else $error("Receiver did not set request three");

  // A pending write with no event stores its low six bits as written.
  chk_pend_write : assert property (
    regBus.wrStb && regBus.addr == mcu_ctrl_pkg::OFS_PEND && events == '0
    |=> s_r.pend == $past(regBus.wrData[5:0]))
    else $error("Pending write not stored");

  // Mode 11 leaves the strobes, the low bus and the upper port 0 address lines undriven.
  chk_float_mode : assert property (
    s_r.activeCfg.p1Mode == mcu_ctrl_pkg::MODE_FLOAT
    |-> !strobeOutEn && !extPins.lowBusOutEn && !(port0HiAddrSel && port0HiOutEn))
    else $error("Bus driven in float mode");

  // The active setting never moves during an access.
  chk_cfg_stable : assert property (
    s_r.seq != mcu_ctrl_pkg::SEQ_IDLE |=> $stable(s_r.activeCfg))
    else $error("Port mode changed mid access");

  // Between accesses the stack choice follows the register.
  chk_stack_select : assert property (
    s_r.seq == mcu_ctrl_pkg::SEQ_IDLE ##1 s_r.seq == mcu_ctrl_pkg::SEQ_IDLE
    |-> stackInternal == $past(s_r.port01.stackInt))
    else $error("Stack selection not applied");

  // In bus mode the address goes out on the low bus.
  chk_p1_bus_addr : assert property (
    extPins.addressStrobeN == 1'b0 && s_r.activeCfg.p1Mode == mcu_ctrl_pkg::MODE_BUS |-> extPins.lowBusOutEn)
    else $error("Low bus not driven with address");

  // An input nibble is neither driven nor used for address.
  chk_p0_lo_input : assert property (
    s_r.activeCfg.p0LoMode == mcu_ctrl_pkg::MODE_IN |-> !port0LoOutEn && !port0LoAddrSel)
    else $error("Lower port 0 input driven");

endmodule

// [tb/ext_mem_model.sv]
// Passive model of the external memory that watches the multiplexed bus pins.
`timescale 1ns/1ps

module ext_mem_model (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Bus pins from the block.
  input  wire mcu_ctrl_pkg::extbus_s pins,
  // What the memory saw, for the bench.
  output logic [15:0]                addrSeen,
  output logic [7:0]                 dataSeen,
  output logic [7:0]                 dsLow
);
  ////////////////////////////////////////////////////////////////////////////////
  // Latch the address while the address strobe is low, as a real memory would.
  // The data strobe width is counted in clocks so that extended timing can be seen.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      addrSeen <= 16'h0000;
      dataSeen <= 8'h00;
      dsLow    <= 8'h00;
    end else begin
      if (!pins.addressStrobeN) begin
        addrSeen <= {pins.addrHigh, pins.muxedLowBus};
        dsLow    <= 8'h00; // A new access restarts the width count.
      end
      if (!pins.dataStrobeN) begin
        dsLow <= dsLow + 8'h01;
        // Write data is only taken while the block really drives the bus.
        if (!pins.readWriteN && pins.lowBusOutEn) begin
          dataSeen <= pins.muxedLowBus;
        end
      end
    end
  end
endmodule

// [tb/mcu_port_irq_control_regs_test.sv]
// Self-checking bench for the control register bank with an external memory model.
`timescale 1ns/1ps

module mcu_port_irq_control_regs_test;
  // Stimulus.
  logic                  clk = 1'b0;
  logic                  reset;
  mcu_ctrl_pkg::regbus_s regBus;
  mcu_ctrl_pkg::extreq_s extReq;
  logic [3:0]            port3In;
  logic                  serialRxReady;
  // Design outputs and model observations.
  logic [7:0]            rdData;
  logic                  extDone;
  mcu_ctrl_pkg::extbus_s extPins;
  logic                  strobeOutEn;
  logic [7:0]            port2OutEn;
  logic [3:0]            port0Use;
  logic                  port1OutEn;
  logic                  stackInternal;
  logic [15:0]           stackPointer;
  logic                  irqOut;
  logic [15:0]           addrSeen;
  logic [7:0]            dataSeen;
  logic [7:0]            dsLow;
  logic [7:0]            prioOut, p3CfgOut, wgpOut, flagsOut;
  // Bookkeeping.
  int                    n_fail = 0;
  int                    checks = 0;
  int                    cycles = 0;
  logic [7:0]            cfg;
  logic                  expEn;

  // The clock toggles every 4 ns, half of its 8 ns period.
  always #4 clk = ~clk;

  mcu_port_irq_control_regs u_dut (
    .clk(clk), .reset(reset), .regBus(regBus), .rdData(rdData),
    .extReq(extReq), .extDone(extDone), .extPins(extPins), .strobeOutEn(strobeOutEn),
    .port2OutEn(port2OutEn), .port0HiOutEn(port0Use[3]), .port0HiAddrSel(port0Use[2]),
    .port0LoOutEn(port0Use[1]), .port0LoAddrSel(port0Use[0]), .port1OutEn(port1OutEn),
    .stackInternal(stackInternal), .stackPointer(stackPointer), .workingGroupPointer(wgpOut),
    .conditionFlags(flagsOut), .port3Config(p3CfgOut), .interruptPriority(prioOut),
    .port3In(port3In), .serialRxReady(serialRxReady), .serialTxDone(1'b0),
    .timer0Done(1'b0), .timer1Done(1'b0), .irqOut(irqOut)
  );

  ext_mem_model u_mem (
    .clk(clk), .reset(reset), .pins(extPins),
    .addrSeen(addrSeen), .dataSeen(dataSeen), .dsLow(dsLow)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one result; case inequality so that an unknown never passes.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One write cycle on the register port; a gap edge follows so strobes never collide.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regBus <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge clk);
    regBus.wrStb <= 1'b0;
  endtask

  // One read cycle; the answer stands only in the cycle after the strobe.
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regBus <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge clk);
    regBus.rdStb <= 1'b0;
    #1;
    chk({8'h00, rdData}, {8'h00, exp});
  endtask

  // A write and at once a read of the same place, strobes back to back.
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regBus <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge clk);
    regBus <= '{addr: a, wrData: d, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge clk);
    regBus.rdStb <= 1'b0;
    #1;
    chk({8'h00, rdData}, {8'h00, d});
  endtask

  // One external write; the request is a single pulse taken while idle.
  task automatic ext(input logic [15:0] a, input logic [7:0] d, input int lat, input int dsw);
    int n;
    n = 0;
    @(posedge clk);
    extReq <= '{req: 1'b1, write: 1'b1, addr: a, data: d};
    do begin
      @(posedge clk);
      extReq.req <= 1'b0;
      #1;
      n++;
    end while (extDone !== 1'b1 && n < 20);
    chk(16'(n), 16'(lat));
    chk(addrSeen, a);
    chk({8'h00, dataSeen}, {8'h00, d});
    chk({8'h00, dsLow}, 16'(dsw));
  endtask

  // Print the counts and the verdict, then stop.
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // A hang is cut short well beyond the expected run of under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end

  // Main sequence of tests.
  initial begin
    reset = 1'b1;
    regBus = '0;
    extReq = '0;
    port3In = 4'hf;
    serialRxReady = 1'b0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    // Everything comes out of reset as input, stack internal, no interrupt.
    chk({port2OutEn, port0Use, port1OutEn, strobeOutEn, stackInternal, irqOut}, 16'h0002);
    // Direction bits: one is input, zero is output; mode registers never read back.
    wr(mcu_ctrl_pkg::OFS_PORT2_DIR, 8'ha5);
    @(posedge clk);
    #1;
    chk({8'h00, port2OutEn}, 16'h005a);
    wr(mcu_ctrl_pkg::OFS_PRIO, 8'h3c);
    wr(mcu_ctrl_pkg::OFS_PORT3_CFG, 8'h5c);
    rdc(mcu_ctrl_pkg::OFS_PORT3_CFG, 8'h00);
    chk({p3CfgOut, prioOut}, 16'h5c3c);
    rdc(mcu_ctrl_pkg::OFS_PRIO, 8'h00);
    rdc(mcu_ctrl_pkg::OFS_PORT2_DIR, 8'h00);
    rdc(mcu_ctrl_pkg::OFS_PORT01, 8'h00);
    // Unmapped places accept nothing and read zero.
    wr(8'h10, 8'h77);
    rdc(8'h10, 8'h00);
    rdc(8'hf0, 8'h00);
    // Read-write registers hold their value; both stack bytes form the pointer.
    for (int i = 0; i < 5; i++) begin
      wrrd(mcu_ctrl_pkg::OFS_MASK + 8'(i), 8'(i) ^ 8'h5a);
    end
    chk(stackPointer, 16'h595e);
    chk({wgpOut, flagsOut}, 16'h585b);
    wr(mcu_ctrl_pkg::OFS_PEND, 8'h3f);
    rdc(mcu_ctrl_pkg::OFS_PEND, 8'h3f);
    // Every combination of the port 0 nibble mode, both nibbles set alike, and the port 1 mode.
    for (int p = 0; p < 4; p++) begin
      for (int m = 0; m < 4; m++) begin
        cfg = {m[1:0], 1'b0, p[1:0], p[0], m[1:0]};
        expEn = (m == 0) || (m[1] && p != 3);
        wr(mcu_ctrl_pkg::OFS_PORT01, cfg);
        @(posedge clk);
        #1;
        chk({12'h000, port0Use}, {12'h000, expEn, m[1], expEn, m[1]});
        chk({port1OutEn, strobeOutEn, stackInternal}, {p == 0, p == 2, p[0]});
      end
    end
    // External writes with normal and with extended timing.
    wr(mcu_ctrl_pkg::OFS_PORT01, 8'h92);
    ext(16'h1234, 8'h5a, 4, 2);
    wr(mcu_ctrl_pkg::OFS_PORT01, 8'hb2);
    ext(16'hbeef, 8'hc3, 6, 4);
    // A timing change written mid-access leaves that access alone.
    fork
      ext(16'h0f0f, 8'h99, 6, 4);
      begin
        repeat (2) @(posedge clk);
        wr(mcu_ctrl_pkg::OFS_PORT01, 8'h92);
      end
    join
    ext(16'h4321, 8'h66, 4, 2);
    // Interrupts: request 3 (serial receive or port 3 line 0) is unmasked, requests 0 and 1 from port 3 lines 2 and 3 are not.
    wr(mcu_ctrl_pkg::OFS_PEND, 8'h00);
    wr(mcu_ctrl_pkg::OFS_MASK, 8'h88);
    @(posedge clk);
    serialRxReady <= 1'b1;
    @(posedge clk);
    serialRxReady <= 1'b0;
    #1;
    chk({15'h0000, irqOut}, 16'h0001);
    rdc(mcu_ctrl_pkg::OFS_PEND, 8'h08);
    wr(mcu_ctrl_pkg::OFS_PEND, 8'h00);
    @(posedge clk);
    #1;
    chk({15'h0000, irqOut}, 16'h0000);
    @(posedge clk);
    port3In <= 4'h3;
    repeat (6) @(posedge clk);
    rdc(mcu_ctrl_pkg::OFS_PEND, 8'h03);
    chk({15'h0000, irqOut}, 16'h0000);
    @(posedge clk);
    port3In <= 4'h2;
    repeat (6) @(posedge clk);
    rdc(mcu_ctrl_pkg::OFS_PEND, 8'h0b);
    chk({15'h0000, irqOut}, 16'h0001);
    finish_test();
  end
endmodule
